/* hw/ext_bank_pkg.sv */
// constants for the external bank decoder and boot strap block
package ext_bank_pkg;
  // register byte offsets (axi4-lite)
  localparam logic [7:0] BANK0_CONFIG_OFF = 8'h00;
  localparam logic [7:0] BANK1_CONFIG_OFF = 8'h04;
  localparam logic [7:0] BANK2_CONFIG_OFF = 8'h08;
  localparam logic [7:0] BANK3_CONFIG_OFF = 8'h0C;
  localparam logic [7:0] STRAP_STATUS_OFF = 8'h10;
  localparam logic [7:0] XFER_CTRL_OFF    = 8'h14;
  localparam logic [7:0] XFER_ADDR_OFF    = 8'h18;
  localparam logic [7:0] XFER_STATUS_OFF  = 8'h1C;

  // bank config field layout
  localparam int RD_WAIT_LSB = 5;
  localparam int WR_WAIT_LSB = 11;
  localparam int WAIT_W      = 5;
  localparam int WIDTH_LSB   = 28;
  localparam logic [31:0] BANK_CONFIG_RESET = 32'h2000_FBEF;
  localparam logic [31:0] BANK_CONFIG_MASK  = 32'h3F00_FFFF;

  // external bank window
  localparam logic [5:0]  EXT_REGION = 6'h20;
  localparam int          BANK_LSB   = 24;

  // boot widths / strap results
  typedef enum logic [1:0] {
    BOOT_8   = 2'b00,
    BOOT_16  = 2'b01,
    BOOT_32  = 2'b10,
    BOOT_INT = 2'b11
  } boot_mode_t;

  // software timing advice, 100 MHz
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RD_MARGIN_NS    = 20;
  localparam int RD_OFFSET_CYC   = 2;
  localparam int WR_MARGIN_NS    = 5;
  localparam int WAIT_BASE_CYC   = 3;
  localparam int STRAP_SETTLE_CYC = 1;
endpackage

/* hw/bank_decode.sv */
// address to active-low bank chip select decoder
`timescale 1ns/1ns
module bank_decode (
  input  wire logic [31:0] addr,
  input  wire logic        active,
  output logic      [3:0]  select_n,
  output logic             hit
);
  always_comb begin
    select_n = 4'hF;
    hit      = 1'b0;
    if (active && addr[31:26] == ext_bank_pkg::EXT_REGION) begin
      hit = 1'b1;
      select_n[addr[ext_bank_pkg::BANK_LSB +: 2]] = 1'b0;
    end
  end
endmodule // bank_decode

/* hw/ext_bank_ctrl.sv */
// external bank controller: strap capture, chip select decode, wait timing, axi4-lite regs
// Contract
// - latch strap pins once after reset; open pins read 1, tied-low read 0
// - boot straps lo/hi give 32, hi/lo 16, lo/lo 8 bit, hi/hi internal flash
// - trace strap low routes port 1 bits 16-25 to trace, else general pins
// - debug strap low routes port 1 bits 26-31 to debug, else general pins
// - programming pin low at reset release starts in-system programming handler
// - boot input high pulls programming pin low; otherwise pull-up holds it high
// - four fixed 16 MByte banks from 0x80000000 each drive only own select
// - one config register per bank sets timing and type; ranges fixed
`timescale 1ns/1ns
module ext_bank_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        boot_sel_strap_lo,
  input  wire logic        boot_sel_strap_hi,
  input  wire logic        trace_enable_strap,
  input  wire logic        debug_enable_strap,
  input  wire logic        isp_request_pin,
  input  wire logic        boot_request_in,
  output logic             isp_pull_low_oe,
  output logic      [1:0]  boot_mode,
  output logic             trace_port_enable,
  output logic             debug_port_enable,
  output logic             in_system_programming,
  output logic             bank0_select_n,
  output logic             bank1_select_n,
  output logic             bank2_select_n,
  output logic             bank3_select_n,
  output logic             ext_write_n,
  output logic             ext_read_n
);
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_WAIT = 2'b01,
    XF_DONE = 2'b10
  } xfer_state_t;

  // strap capture: one sample on the first edge after release
  logic       strap_done_reg, strap_done_next;
  logic [1:0] boot_reg, boot_next;
  logic       trace_reg, trace_next;
  logic       debug_reg, debug_next;
  logic       isp_reg, isp_next;
  // registers
  logic [31:0] cfg_reg [4];
  logic [31:0] cfg_next [4];
  logic [31:0] addr_reg, addr_next;
  // axi slave state
  logic        aw_held_reg, aw_held_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  // transfer engine
  xfer_state_t xf_reg, xf_next;
  logic        xf_write_reg, xf_write_next;
  logic [5:0]  xf_cnt_reg, xf_cnt_next;
  logic        xf_done_reg, xf_done_next;
  logic        xf_miss_reg, xf_miss_next;

  logic [3:0]  sel_n;
  logic        bank_hit;
  logic        do_write;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [5:0] wait_cycles(input logic [4:0] w);
    return 6'(w) + 6'(ext_bank_pkg::WAIT_BASE_CYC);
  endfunction

  bank_decode u_dec (
    .addr     (addr_reg),
    .active   (xf_reg == XF_WAIT),
    .select_n (sel_n),
    .hit      (bank_hit)
  );

  always_comb begin
    strap_done_next = strap_done_reg;
    boot_next       = boot_reg;
    trace_next      = trace_reg;
    debug_next      = debug_reg;
    isp_next        = isp_reg;
    if (!strap_done_reg) begin
      strap_done_next = 1'b1;
      boot_next  = {boot_sel_strap_hi, boot_sel_strap_lo} == 2'b10 ? ext_bank_pkg::BOOT_32 :
                   {boot_sel_strap_hi, boot_sel_strap_lo} == 2'b01 ? ext_bank_pkg::BOOT_16 :
                   {boot_sel_strap_hi, boot_sel_strap_lo} == 2'b00 ? ext_bank_pkg::BOOT_8 :
                   ext_bank_pkg::BOOT_INT;
      trace_next = ~trace_enable_strap;
      debug_next = ~debug_enable_strap;
      isp_next   = ~isp_request_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_reg <= 1'b0;
      boot_reg       <= ext_bank_pkg::BOOT_INT;
      trace_reg      <= 1'b0;
      debug_reg      <= 1'b0;
      isp_reg        <= 1'b0;
    end else begin
      strap_done_reg <= strap_done_next;
      boot_reg       <= boot_next;
      trace_reg      <= trace_next;
      debug_reg      <= debug_next;
      isp_reg        <= isp_next;
    end
  end

  assign boot_mode             = boot_reg;
  assign trace_port_enable     = trace_reg;
  assign debug_port_enable     = debug_reg;
  assign in_system_programming = isp_reg;
  assign isp_pull_low_oe       = boot_request_in;

  // axi4-lite write and read paths
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign do_write      = aw_held_reg && w_held_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    addr_next    = addr_reg;
    xf_write_next = xf_write_reg;
    for (int i = 0; i < 4; i++) cfg_next[i] = cfg_reg[i];
    xf_next      = xf_reg;
    xf_cnt_next  = xf_cnt_reg;
    xf_done_next = xf_done_reg;
    xf_miss_next = xf_miss_reg;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = 2'b00;
      case (aw_addr_reg[7:2])
        ext_bank_pkg::BANK0_CONFIG_OFF[7:2], ext_bank_pkg::BANK1_CONFIG_OFF[7:2],
        ext_bank_pkg::BANK2_CONFIG_OFF[7:2], ext_bank_pkg::BANK3_CONFIG_OFF[7:2]: begin
          // timing and type only; no address field exists
          cfg_next[aw_addr_reg[3:2]] = merge(cfg_reg[aw_addr_reg[3:2]], w_data_reg, w_strb_reg)
                                       & ext_bank_pkg::BANK_CONFIG_MASK;
        end
        ext_bank_pkg::XFER_ADDR_OFF[7:2]: begin
          addr_next = merge(addr_reg, w_data_reg, w_strb_reg);
        end
        ext_bank_pkg::XFER_CTRL_OFF[7:2]: begin
          if (w_strb_reg[0] && w_data_reg[0] && xf_reg == XF_IDLE) begin
            xf_write_next = w_data_reg[1];
            xf_next       = XF_WAIT;
            xf_done_next  = 1'b0;
            xf_miss_next  = 1'b0;
            xf_cnt_next   = wait_cycles(w_data_reg[1]
              ? cfg_reg[addr_reg[25:24]][ext_bank_pkg::WR_WAIT_LSB +: ext_bank_pkg::WAIT_W]
              : cfg_reg[addr_reg[25:24]][ext_bank_pkg::RD_WAIT_LSB +: ext_bank_pkg::WAIT_W]);
          end
        end
        ext_bank_pkg::XFER_STATUS_OFF[7:2], ext_bank_pkg::STRAP_STATUS_OFF[7:2]: begin
        end
        default: bresp_next = 2'b10;
      endcase
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;

    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = 2'b00;
      case (s_axi_araddr[7:2])
        ext_bank_pkg::BANK0_CONFIG_OFF[7:2], ext_bank_pkg::BANK1_CONFIG_OFF[7:2],
        ext_bank_pkg::BANK2_CONFIG_OFF[7:2], ext_bank_pkg::BANK3_CONFIG_OFF[7:2]:
          rdata_next = cfg_reg[s_axi_araddr[3:2]];
        ext_bank_pkg::STRAP_STATUS_OFF[7:2]:
          rdata_next = {27'h0, isp_reg, debug_reg, trace_reg, boot_reg};
        ext_bank_pkg::XFER_ADDR_OFF[7:2]:
          rdata_next = addr_reg;
        ext_bank_pkg::XFER_CTRL_OFF[7:2]:
          rdata_next = {30'h0, xf_write_reg, 1'b0};
        ext_bank_pkg::XFER_STATUS_OFF[7:2]:
          rdata_next = {29'h0, xf_miss_reg, xf_done_reg, xf_reg == XF_WAIT};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = 2'b10;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end

    // access strobe held for the configured wait count plus WAIT_BASE_CYC cycles
    case (xf_reg)
      XF_IDLE: ;
      XF_WAIT: begin
        if (!bank_hit) begin
          xf_miss_next = 1'b1;
          xf_next      = XF_DONE;
        end else if (xf_cnt_reg <= 6'h01) begin
          xf_next = XF_DONE;
        end else begin
          xf_cnt_next = xf_cnt_reg - 6'h01;
        end
      end
      XF_DONE: begin
        xf_done_next = 1'b1;
        xf_next      = XF_IDLE;
      end
      default: xf_next = XF_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= 2'b00;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= 2'b00;
      addr_reg     <= 32'h0000_0000;
      xf_reg       <= XF_IDLE;
      xf_write_reg <= 1'b0;
      xf_cnt_reg   <= 6'h00;
      xf_done_reg  <= 1'b0;
      xf_miss_reg  <= 1'b0;
      for (int i = 0; i < 4; i++) cfg_reg[i] <= ext_bank_pkg::BANK_CONFIG_RESET;
    end else begin
      aw_held_reg  <= aw_held_next;
      aw_addr_reg  <= aw_addr_next;
      w_held_reg   <= w_held_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      addr_reg     <= addr_next;
      xf_reg       <= xf_next;
      xf_write_reg <= xf_write_next;
      xf_cnt_reg   <= xf_cnt_next;
      xf_done_reg  <= xf_done_next;
      xf_miss_reg  <= xf_miss_next;
      for (int i = 0; i < 4; i++) cfg_reg[i] <= cfg_next[i];
    end
  end

  // selects come straight from the fixed decode
  assign bank0_select_n = sel_n[0];
  assign bank1_select_n = sel_n[1];
  assign bank2_select_n = sel_n[2];
  assign bank3_select_n = sel_n[3];
  assign ext_write_n    = !(xf_reg == XF_WAIT && bank_hit && xf_write_reg);
  assign ext_read_n     = !(xf_reg == XF_WAIT && bank_hit && !xf_write_reg);
endmodule // ext_bank_ctrl

/* dv/ext_bank_ctrl_monitor.sv */
// port assertions for the external bank controller
`timescale 1ns/1ns
module ext_bank_ctrl_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       boot_sel_strap_lo,
  input wire logic       boot_sel_strap_hi,
  input wire logic       trace_enable_strap,
  input wire logic       debug_enable_strap,
  input wire logic       isp_request_pin,
  input wire logic       boot_request_in,
  input wire logic       isp_pull_low_oe,
  input wire logic [1:0] boot_mode,
  input wire logic       trace_port_enable,
  input wire logic       debug_port_enable,
  input wire logic       in_system_programming,
  input wire logic       bank0_select_n,
  input wire logic       bank1_select_n,
  input wire logic       bank2_select_n,
  input wire logic       bank3_select_n,
  input wire logic       ext_write_n,
  input wire logic       ext_read_n
);
  logic [3:0] sel_n;
  logic       idle;
  assign sel_n = {bank3_select_n, bank2_select_n, bank1_select_n, bank0_select_n};
  assign idle  = ext_read_n & ext_write_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  strap_boot_a: assert property (aresetn && !$past(aresetn) |=>
    boot_mode == $past({boot_sel_strap_hi, boot_sel_strap_lo})) else $error("boot mode wrong");
  strap_enable_a: assert property (aresetn && !$past(aresetn) |=>
    {trace_port_enable, debug_port_enable, in_system_programming} ==
    $past({!trace_enable_strap, !debug_enable_strap, !isp_request_pin}))
    else $error("strap enables wrong");
  strap_hold_a: assert property (aresetn && $past(aresetn) && $past(aresetn, 2) |->
    $stable({boot_mode, trace_port_enable, debug_port_enable, in_system_programming}))
    else $error("strap outputs moved");
  isp_pull_a: assert property (isp_pull_low_oe == boot_request_in)
    else $error("pull-low enable wrong");
  one_select_a: assert property ($onehot0(~sel_n)) else $error("two selects low");
  select_strobe_a: assert property (!(&sel_n) |-> !idle)
    else $error("select without strobe");
  strobe_len_a: assert property ($fell(idle) |-> ##[3:34] idle)
    else $error("strobe length out of range");
  select_steady_a: assert property (!idle && !$past(idle) |-> $stable(sel_n))
    else $error("select moved in access");
  cover property ($fell(ext_read_n));
  cover property ($fell(ext_write_n));
  cover property (isp_pull_low_oe);
endmodule // ext_bank_ctrl_monitor

bind ext_bank_ctrl ext_bank_ctrl_monitor ext_bank_ctrl_monitor_i (.*);

/* dv/ext_mem_model.sv */
// external memory bank model: times each strobe and records the chip selects seen
`timescale 1ns/1ns
module ext_mem_model (
  input  wire logic       aclk,
  input  wire logic       bank0_select_n,
  input  wire logic       bank1_select_n,
  input  wire logic       bank2_select_n,
  input  wire logic       bank3_select_n,
  input  wire logic       ext_write_n,
  input  wire logic       ext_read_n,
  output logic            mdone,
  output logic            mwr,
  output logic      [3:0] msel,
  output logic      [5:0] mlen
);
  logic [5:0] cnt = 6'h00;
  initial mdone = 1'b0;
  always @(posedge aclk) begin
    mdone <= 1'b0;
    if (!(ext_read_n && ext_write_n)) begin
      cnt  <= cnt + 6'h01;
      mwr  <= !ext_write_n;
      msel <= {bank3_select_n, bank2_select_n, bank1_select_n, bank0_select_n};
    end else if (cnt != 6'h00) begin
      mdone <= 1'b1;
      mlen  <= cnt;
      cnt   <= 6'h00;
    end
  end
endmodule // ext_mem_model

/* dv/ext_bank_ctrl_tb.sv */
// self-checking testbench for the external bank controller
`timescale 1ns/1ns
module ext_bank_ctrl_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, boot_request_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, msel;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, isp_request_pin = 1'b1;
  logic        boot_sel_strap_lo = 1'b1, boot_sel_strap_hi = 1'b1;
  logic        trace_enable_strap = 1'b1, debug_enable_strap = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        isp_pull_low_oe, trace_port_enable, debug_port_enable, in_system_programming;
  logic        bank0_select_n, bank1_select_n, bank2_select_n, bank3_select_n;
  logic        ext_write_n, ext_read_n, mdone, mwr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, boot_mode;
  logic [5:0]  mlen;
  logic [33:0] qr[$];
  logic [1:0]  qw[$];
  logic [10:0] qx[$];
  int          n_mismatch = 0, total_checks = 0, seed = 10419, i, j;

  ext_bank_ctrl ext_bank_ctrl_i (.*);
  ext_mem_model ext_mem_model_i (.*);
  always #5 aclk = ~aclk;

  task automatic chk(input logic [33:0] g, input logic [33:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic lim(input int n);
    if (n >= 60) begin
      n_mismatch++;
      $display("MISMATCH %0t wait timed out", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    qw.push_back(e);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 60 && !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    lim(n);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    qr.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 60 && !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    lim(n);
  endtask

  // straps change one edge after the latching edge, so held outputs are exercised
  task automatic do_reset(input logic [4:0] s);
    aresetn <= 1'b0;
    {isp_request_pin, debug_enable_strap, trace_enable_strap, boot_sel_strap_hi,
     boot_sel_strap_lo} <= s;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    {isp_request_pin, debug_enable_strap, trace_enable_strap, boot_sel_strap_hi,
     boot_sel_strap_lo} <= 5'($random(seed));
    chk(boot_mode, {s[1], s[0]}, "boot mode");
    chk({trace_port_enable, debug_port_enable, in_system_programming},
        {!s[2], !s[3], !s[4]}, "strap enables");
    repeat (3) @(posedge aclk);
    chk(boot_mode, {s[1], s[0]}, "boot hold");
    rd(ext_bank_pkg::STRAP_STATUS_OFF, {29'h0, !s[4], !s[3], !s[2], s[1:0]});
  endtask

  task automatic access(input logic [1:0] b, input logic w, input int t);
    logic [4:0]  ws;
    logic [31:0] cfg, a;
    int          n;
    // round up so the count never falls below the minimum for the part
    ws  = w ? 5'((t + ext_bank_pkg::WR_MARGIN_NS - 1) / ext_bank_pkg::CLK_PERIOD_NS)
            : 5'((t + ext_bank_pkg::RD_MARGIN_NS + ext_bank_pkg::CLK_PERIOD_NS - 1)
                 / ext_bank_pkg::CLK_PERIOD_NS - ext_bank_pkg::RD_OFFSET_CYC);
    cfg = 32'h2000_0000 | (32'(ws) << (w ? ext_bank_pkg::WR_WAIT_LSB : ext_bank_pkg::RD_WAIT_LSB));
    a   = {ext_bank_pkg::EXT_REGION, b, 24'($random(seed))};
    wr({4'h0, b, 2'b00}, cfg, 2'b00);
    rd({4'h0, b, 2'b00}, {2'b00, cfg});
    wr(ext_bank_pkg::XFER_ADDR_OFF, a, 2'b00);
    rd(ext_bank_pkg::XFER_ADDR_OFF, {2'b00, a});
    qx.push_back({w, ~(4'h1 << b), 6'(ws) + 6'd3});
    wr(ext_bank_pkg::XFER_CTRL_OFF, {30'h0, w, 1'b1}, 2'b00);
    rd(ext_bank_pkg::XFER_CTRL_OFF, {32'h0, w, 1'b0});
    for (n = 0; n < 60 && qx.size() > 0; n++) @(posedge aclk);
    lim(n);
    rd(ext_bank_pkg::XFER_STATUS_OFF, 34'h2);
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, qr.pop_front(), "read");
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, qw.pop_front(), "write resp");
    if (mdone && qx.size() == 0) begin
      n_mismatch++;
      $display("MISMATCH %0t access without request", $time);
    end else if (mdone) begin
      chk({mwr, msel, mlen}, qx.pop_front(), "bus access");
    end
  end

  initial begin
    for (i = 0; i < 4; i++) do_reset({3'($random(seed)), 2'(i)});
    $display("strap test done");
    for (i = 0; i < 4; i++) begin
      rd(8'(i * 4), {2'b00, ext_bank_pkg::BANK_CONFIG_RESET});
      j = $random(seed);
      wr(8'(i * 4), j, 2'b00);
      rd(8'(i * 4), {2'b00, 32'(j) & ext_bank_pkg::BANK_CONFIG_MASK});
    end
    rd(8'h20, {2'b10, 32'h0});
    wr(8'h24, 32'h1, 2'b10);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      boot_request_in <= 1'($random(seed));
      access(2'(i / 2), 1'(i), (i / 2 == 3) ? 310 : 10 + ($random(seed) & 63));
    end
    $display("access test done");
    for (i = 0; i < 2; i++) begin
      wr(ext_bank_pkg::XFER_ADDR_OFF, i ? 32'h7FFF_FFFF : 32'h8400_0000, 2'b00);
      wr(ext_bank_pkg::XFER_CTRL_OFF, 32'h1, 2'b00);
      rd(ext_bank_pkg::XFER_STATUS_OFF, 34'h6);
    end
    $display("miss test done");
    finish_test();
  end
endmodule // ext_bank_ctrl_tb
